// file: verilog/orf_filter.sv
// Outbound response event filter with its configuration register
`timescale 1ns/1ps
`include "orf_defines.svh"

module orf_filter
    import orf_pkg::*;
#(
    parameter int NUM_CTR = 4
) (
    // Clock, reset and enable
    input  wire logic                       CORE_CLK_IN,
    input  wire logic                       SYS_RST_IN,
    input  wire logic                       CORE_CE_IN,
    // Model-specific register access
    input  wire orf_msr_req_s               MSR_REQ_IN,
    output logic [63:0]                     MSR_RDATA_OUT,
    output logic                            MSR_ACK_OUT,
    output logic                            MSR_MISS_OUT,
    // Completed outbound transactions
    input  wire orf_txn_s                   TXN_IN,
    // Event selection of each general counter
    input  wire orf_evsel_s [NUM_CTR-1:0]   EVSEL_IN,
    // Increment pulses to the general counters
    output logic [NUM_CTR-1:0]              CTR_INC_OUT,
    // Current filter setting
    output logic [`ORF_CFG_WIDTH-1:0]       FILTER_CFG_OUT
);

    // Configuration register state
    logic [`ORF_CFG_WIDTH-1:0]  cfg;
    logic [`ORF_CFG_WIDTH-1:0]  next_cfg;

    // Answer registers of the access port
    logic [63:0]                rdata;
    logic                       ack;
    logic                       miss;

    // Captured transaction stage
    orf_txn_s                   txn_q;

    // Increment pulses
    logic [NUM_CTR-1:0]         inc;
    logic [NUM_CTR-1:0]         next_inc;

    // Access decode
    wire                        acc_any;
    wire                        acc_hit;
    wire                        cfg_write;
    wire [63:0]                 cfg_readback;

    // Field views of the configuration
    wire [7:0]                  req_sel;
    wire [7:0]                  rsp_sel;

    // Class of the captured transaction
    logic [7:0]                 req_bit;
    logic [7:0]                 rsp_bit;
    wire                        req_match;
    wire                        rsp_match;
    wire                        txn_match;

    // Decode of register accesses: one address only
    assign acc_any   = MSR_REQ_IN.wr | MSR_REQ_IN.rd;
    assign acc_hit   = (MSR_REQ_IN.addr == `ORF_CFG_ADDR);
    assign cfg_write = MSR_REQ_IN.wr & acc_hit;

    // Reserved bit is never stored, so it reads as zero
    assign next_cfg = cfg_write ?
        (MSR_REQ_IN.wdata[`ORF_CFG_WIDTH-1:0] & `ORF_CFG_WMASK) :
        cfg;

    // Upper bits of the register read as zero
    assign cfg_readback = {{(64-`ORF_CFG_WIDTH){1'b0}}, cfg};

    // Field views
    assign req_sel = cfg[`ORF_REQ_MSB:`ORF_REQ_LSB];
    assign rsp_sel = cfg[`ORF_RSP_MSB:`ORF_RSP_LSB];

    // Configuration register
    always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            cfg <= `ORF_CFG_RESET;
        end else if (CORE_CE_IN) begin
            cfg <= next_cfg;
        end
    end

    // Access answer: one cycle after the request, unmapped reads give zero
    always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rdata <= 64'h0000_0000_0000_0000;
            ack   <= 1'b0;
            miss  <= 1'b0;
        end else if (CORE_CE_IN) begin
            ack   <= acc_any;
            miss  <= acc_any & ~acc_hit;
            rdata <= (MSR_REQ_IN.rd & acc_hit) ? cfg_readback :
                     64'h0000_0000_0000_0000;
        end
    end

    // Request-type class of the captured transaction
    always_comb begin
        req_bit = 8'h00;
        case (txn_q.kind)
            // Demand, first-level prefetch and table-walk data reads
            ORF_K_REQ_DEMAND_DATA_READ,
            ORF_K_DCU_REQ_PREFETCH_DATA_READ,
            ORF_K_PTE_RD: begin
                req_bit[`ORF_REQ_DMND_DATA] = 1'b1;
            end
            // Demand and first-level prefetch ownership reads
            ORF_K_DMND_OWN_RD,
            ORF_K_DCU_PF_OWN_RD: begin
                req_bit[`ORF_REQ_DMND_OWN] = 1'b1;
            end
            // Demand and first-level prefetch code reads
            ORF_K_DMND_CODE_RD,
            ORF_K_DCU_PF_CODE_RD: begin
                req_bit[`ORF_REQ_DMND_CODE] = 1'b1;
            end
            // Modified-to-exclusive writebacks
            ORF_K_WRITEBACK: begin
                req_bit[`ORF_REQ_WB] = 1'b1;
            end
            // Second-level prefetcher traffic, each on its own bit
            ORF_K_L2_REQ_PREFETCH_DATA_READ: begin
                req_bit[`ORF_REQ_PF_DATA] = 1'b1;
            end
            ORF_K_L2_PF_OWN_RD: begin
                req_bit[`ORF_REQ_PF_OWN] = 1'b1;
            end
            ORF_K_L2_PF_CODE_RD: begin
                req_bit[`ORF_REQ_PF_CODE] = 1'b1;
            end
            // Everything else shares the catch-all bit
            ORF_K_LLC_INVAL,
            ORF_K_IO,
            ORF_K_WRITE,
            ORF_K_WC_NT_STORE,
            ORF_K_FLUSH,
            ORF_K_FENCE,
            ORF_K_LOCK,
            ORF_K_UNLOCK,
            ORF_K_SPLIT_LOCK: begin
                req_bit[`ORF_REQ_OTHER] = 1'b1;
            end
            // Unknown codes fall into the catch-all as well
            default: begin
                req_bit[`ORF_REQ_OTHER] = 1'b1;
            end
        endcase
    end

    // Service-outcome class of the captured transaction
    always_comb begin
        rsp_bit = 8'h00;
        case (txn_q.rsp)
            // Last-level hit with no coherency action
            ORF_R_LLC_HIT_NO_SNP: begin
                rsp_bit[`ORF_RSP_LLC_HIT] = 1'b1;
            end
            // Hit served by another core, clean snoop
            ORF_R_LLC_HIT_CLEAN: begin
                rsp_bit[`ORF_RSP_CLEAN_SNP] = 1'b1;
            end
            // Hit served by another core, modified copy found
            ORF_R_LLC_HIT_MOD: begin
                rsp_bit[`ORF_RSP_MOD_SNP] = 1'b1;
            end
            // Cross-package forward counts for local home only
            ORF_R_PKG_FORWARD: begin
                rsp_bit[`ORF_RSP_FWD] = ~txn_q.remote_home;
            end
            // Memory service, split by where the line is homed
            ORF_R_MEM: begin
                rsp_bit[`ORF_RSP_REMOTE_MEM] = txn_q.remote_home;
                rsp_bit[`ORF_RSP_LOCAL_MEM]  = ~txn_q.remote_home;
            end
            // Served by the I/O hub rather than memory
            ORF_R_IO_HUB: begin
                rsp_bit[`ORF_RSP_IO_HUB] = 1'b1;
            end
            // Uncached and unknown outcomes select no bit
            default: begin
                rsp_bit = 8'h00;
            end
        endcase
    end

    // A transaction counts when both classes are enabled
    assign req_match = |(req_bit & req_sel);
    assign rsp_match = |(rsp_bit & rsp_sel);
    assign txn_match = txn_q.done & req_match & rsp_match;

    // Capture stage for completed transactions
    always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            txn_q <= '0;
        end else if (CORE_CE_IN) begin
            txn_q <= TXN_IN;
        end
    end

    // Per-counter selection: only the outbound-response event uses the filter
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTR; gi++) begin : g_ctr
            wire sel_hit;
            assign sel_hit = (EVSEL_IN[gi].code == `ORF_EVT_CODE) &&
                             (EVSEL_IN[gi].umask == `ORF_EVT_UMASK);
            assign next_inc[gi] = sel_hit & txn_match;
        end
    endgenerate

    // Increment pulses, one cycle per qualified completion
    always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            inc <= '0;
        end else if (CORE_CE_IN) begin
            inc <= next_inc;
        end
    end

    // Outputs
    assign MSR_RDATA_OUT  = rdata;
    assign MSR_ACK_OUT    = ack;
    assign MSR_MISS_OUT   = miss;
    assign CTR_INC_OUT    = inc;
    assign FILTER_CFG_OUT = cfg;

endmodule // orf_filter

// file: include/orf_defines.svh
// Offsets, field positions, reset values and codes of the response filter
`ifndef ORF_DEFINES_SVH
`define ORF_DEFINES_SVH

// Model-specific address of the filter configuration register
`define ORF_CFG_ADDR        32'h0000_01a6
// Configuration register layout
`define ORF_CFG_WIDTH       16
`define ORF_REQ_LSB         0
`define ORF_REQ_MSB         7
`define ORF_RSP_LSB         8
`define ORF_RSP_MSB         15
`define ORF_RSV_BIT         11
`define ORF_CFG_RESET       16'h0000
// Writable bits: all but the reserved bit
`define ORF_CFG_WMASK       16'hf7ff
// Request bit positions
`define ORF_REQ_DMND_DATA   0
`define ORF_REQ_DMND_OWN    1
`define ORF_REQ_DMND_CODE   2
`define ORF_REQ_WB          3
`define ORF_REQ_PF_DATA     4
`define ORF_REQ_PF_OWN      5
`define ORF_REQ_PF_CODE     6
`define ORF_REQ_OTHER       7
// Response bit positions within the response field
`define ORF_RSP_LLC_HIT     0
`define ORF_RSP_CLEAN_SNP   1
`define ORF_RSP_MOD_SNP     2
`define ORF_RSP_FWD         4
`define ORF_RSP_REMOTE_MEM  5
`define ORF_RSP_LOCAL_MEM   6
`define ORF_RSP_IO_HUB      7
// Event-select code and unit mask of the outbound-response event
`define ORF_EVT_CODE        8'hb7
`define ORF_EVT_UMASK       8'h01

`endif

// file: include/orf_pkg.sv
// Types shared by the outbound response filter and its bench
package orf_pkg;

    // Fine-grained kind of an outbound transaction
    typedef enum logic [4:0] {
        ORF_K_REQ_DEMAND_DATA_READ   = 5'h00,
        ORF_K_DCU_REQ_PREFETCH_DATA_READ = 5'h01,
        ORF_K_PTE_RD         = 5'h02,
        ORF_K_DMND_OWN_RD    = 5'h03,
        ORF_K_DCU_PF_OWN_RD  = 5'h04,
        ORF_K_DMND_CODE_RD   = 5'h05,
        ORF_K_DCU_PF_CODE_RD = 5'h06,
        ORF_K_WRITEBACK      = 5'h07,
        ORF_K_L2_REQ_PREFETCH_DATA_READ  = 5'h08,
        ORF_K_L2_PF_OWN_RD   = 5'h09,
        ORF_K_L2_PF_CODE_RD  = 5'h0a,
        ORF_K_LLC_INVAL      = 5'h0b,
        ORF_K_IO             = 5'h0c,
        ORF_K_WRITE          = 5'h0d,
        ORF_K_WC_NT_STORE    = 5'h0e,
        ORF_K_FLUSH          = 5'h0f,
        ORF_K_FENCE          = 5'h10,
        ORF_K_LOCK           = 5'h11,
        ORF_K_UNLOCK         = 5'h12,
        ORF_K_SPLIT_LOCK     = 5'h13
    } orf_kind_e;

    // Service outcome reported by the shared subsystem
    typedef enum logic [3:0] {
        ORF_R_LLC_HIT_NO_SNP = 4'h0,
        ORF_R_LLC_HIT_CLEAN  = 4'h1,
        ORF_R_LLC_HIT_MOD    = 4'h2,
        ORF_R_PKG_FORWARD    = 4'h3,
        ORF_R_MEM            = 4'h4,
        ORF_R_IO_HUB         = 4'h5,
        ORF_R_UNCACHED       = 4'h6
    } orf_rsp_e;

    // One completed outbound transaction
    typedef struct packed {
        logic      done;
        orf_kind_e kind;
        orf_rsp_e  rsp;
        logic      remote_home;
    } orf_txn_s;

    // Event selection of one core general counter
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] umask;
    } orf_evsel_s;

    // Model-specific register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [63:0] wdata;
    } orf_msr_req_s;

endpackage

// file: tb/orf_filter_properties.sv
// Port checks for the outbound response filter
`timescale 1ns/1ps
`include "orf_defines.svh"
module orf_filter_properties
    import orf_pkg::*;
#(parameter int NUM_CTR = 4) (
    // Clock, reset and enable
    input wire logic                     CORE_CLK_IN,
    input wire logic                     SYS_RST_IN,
    input wire logic                     CORE_CE_IN,
    // Register port
    input wire orf_msr_req_s             MSR_REQ_IN,
    input wire logic [63:0]              MSR_RDATA_OUT,
    input wire logic                     MSR_ACK_OUT,
    input wire logic                     MSR_MISS_OUT,
    // Transaction path
    input wire orf_txn_s                 TXN_IN,
    input wire orf_evsel_s [NUM_CTR-1:0] EVSEL_IN,
    input wire logic [NUM_CTR-1:0]       CTR_INC_OUT,
    input wire logic [15:0]              FILTER_CFG_OUT
);
    // Decoded access and selection conditions
    wire req = CORE_CE_IN && (MSR_REQ_IN.wr || MSR_REQ_IN.rd);
    wire hit = MSR_REQ_IN.addr == `ORF_CFG_ADDR;
    wire sel = EVSEL_IN[0] == {`ORF_EVT_CODE, `ORF_EVT_UMASK};
    wire dd = FILTER_CFG_OUT[0] && FILTER_CFG_OUT[8];
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    access_ack_a: assert property (req |=> MSR_ACK_OUT)
        else $error("access not answered next cycle");
    unmapped_miss_a: assert property (req && !hit |=> MSR_MISS_OUT
        && MSR_RDATA_OUT == 64'h0) else $error("unmapped access wrong");
    cfg_write_a: assert property (req && MSR_REQ_IN.wr && hit |=>
        FILTER_CFG_OUT == ($past(MSR_REQ_IN.wdata[15:0]) & `ORF_CFG_WMASK))
        else $error("config write not applied");
    read_back_a: assert property (req && MSR_REQ_IN.rd && hit |=>
        MSR_RDATA_OUT == {48'h0, $past(FILTER_CFG_OUT)})
        else $error("read data differs from config");
    reserved_zero_a: assert property (!FILTER_CFG_OUT[11])
        else $error("reserved config bit set");
    idle_data_a: assert property (!MSR_ACK_OUT |-> MSR_RDATA_OUT == 64'h0)
        else $error("read data outside ack");
    pulse_cause_a: assert property (CTR_INC_OUT[0] |-> $past(sel)
        && $past(TXN_IN.done, 2)) else $error("increment without cause");
    match_count_a: assert property (CORE_CE_IN && TXN_IN.done && dd
        && TXN_IN.kind == ORF_K_REQ_DEMAND_DATA_READ
        && TXN_IN.rsp == ORF_R_LLC_HIT_NO_SNP
        ##1 sel && dd && CORE_CE_IN |=> CTR_INC_OUT[0])
        else $error("matching completion not counted");
    remote_fwd_a: assert property (TXN_IN.done && TXN_IN.remote_home
        && TXN_IN.rsp == ORF_R_PKG_FORWARD |-> ##2 !CTR_INC_OUT[0])
        else $error("remote forward counted");
endmodule // orf_filter_properties
bind orf_filter orf_filter_properties #(.NUM_CTR(NUM_CTR)) u_props (
    .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .CORE_CE_IN(CORE_CE_IN), .MSR_REQ_IN(MSR_REQ_IN),
    .MSR_RDATA_OUT(MSR_RDATA_OUT), .MSR_ACK_OUT(MSR_ACK_OUT),
    .MSR_MISS_OUT(MSR_MISS_OUT), .TXN_IN(TXN_IN), .EVSEL_IN(EVSEL_IN),
    .CTR_INC_OUT(CTR_INC_OUT), .FILTER_CFG_OUT(FILTER_CFG_OUT));

// file: tb/orf_subsys_model.sv
// Shared subsystem model reporting completed outbound transactions
`timescale 1ns/1ps
module orf_subsys_model
    import orf_pkg::*;
(
    // Clock
    input  wire logic clk_in,
    // Completions to the filter
    output orf_txn_s  txn_out
);
    // Idle at time zero
    initial txn_out = '0;
    // One completion after lat idle cycles; idle fields show no stale value
    task automatic complete(input orf_kind_e kind, input orf_rsp_e rsp,
                            input logic rem, input int lat);
        repeat (lat) @(negedge clk_in);
        txn_out = {1'b1, kind, rsp, rem};
        @(negedge clk_in);
        txn_out = {1'b0, ~kind, ~rsp, ~rem};
    endtask
endmodule // orf_subsys_model

// file: tb/testbench.sv
// Self-checking bench for the outbound response filter
`timescale 1ns/1ps
`include "orf_defines.svh"
module testbench;
    import orf_pkg::*;
    // Stimulus and observed signals
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             ce = 1'b1;
    orf_msr_req_s     req = '0;
    logic [63:0]      rdata;
    logic             ack;
    logic             miss;
    orf_txn_s         txn;
    // Counters 3 and 0 select the filtered event, 2 and 1 do not
    orf_evsel_s [3:0] evsel =
        {16'hb701, 16'hc701, 16'hb700, 16'hb701};
    logic [3:0]       inc;
    logic [15:0]      cfg;
    int               n_fail = 0;
    int               cmp_count = 0;

    // Clock
    always #12.5 clk = ~clk;

    // Design and far-side model
    orf_filter #(.NUM_CTR(4)) dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
        .CORE_CE_IN(ce), .MSR_REQ_IN(req), .MSR_RDATA_OUT(rdata),
        .MSR_ACK_OUT(ack), .MSR_MISS_OUT(miss), .TXN_IN(txn),
        .EVSEL_IN(evsel), .CTR_INC_OUT(inc), .FILTER_CFG_OUT(cfg));
    orf_subsys_model subsys (.clk_in(clk), .txn_out(txn));

    // Compare and count
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One register access, answer checked one cycle later
    task automatic access(input logic wr, input logic rd,
        input logic [31:0] a, input logic [63:0] wd,
        input logic [63:0] exp, input logic em);
        req = '{wr, rd, a, wd};
        @(negedge clk);
        req = '0;
        check({ack, miss}, {1'b1, em});
        check(rdata, exp);
    endtask

    // Program the filter, complete one transaction, check the pulses
    task automatic send(input int k, input int r, input logic rem,
                        input logic [15:0] c, input logic hit);
        access(1'b1, 1'b0, `ORF_CFG_ADDR, {48'h0, c}, 64'h0, 1'b0);
        subsys.complete(orf_kind_e'(k[4:0]), orf_rsp_e'(r[3:0]), rem,
                        k % 2 * 3);
        @(negedge clk);
        check(inc, hit ? 4'h9 : 4'h0);
    endtask

    // Request bit that a kind belongs to
    function automatic int req_bit(input int k);
        if (k <= 2) return 0;
        if (k <= 4) return 1;
        if (k <= 6) return 2;
        if (k <= 10) return k - 4;
        return 7;
    endfunction

    // Response bit that an outcome selects, 16 for none
    function automatic int rsp_bit(input int r, input logic rem);
        case (r)
            3: return rem ? 16 : 12;
            4: return rem ? 13 : 14;
            5: return 15;
            6: return 16;
            default: return r + 8;
        endcase
    endfunction

    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(cfg, 16'h0000);
        access(1'b0, 1'b1, `ORF_CFG_ADDR, 64'h0, 64'h0, 1'b0);
        access(1'b1, 1'b1, `ORF_CFG_ADDR, '1, 64'h0, 1'b0);
        access(1'b0, 1'b1, `ORF_CFG_ADDR, 64'h0, 64'hf7ff, 1'b0);
        access(1'b1, 1'b0, 32'h0000_01a7, 64'h0, 64'h0, 1'b1);
        access(1'b0, 1'b1, 32'h0000_01a7, 64'h0, 64'h0, 1'b1);
        // A write while the enable is low must leave the register alone
        ce = 1'b0;
        req = '{1'b1, 1'b0, `ORF_CFG_ADDR, 64'h0};
        @(negedge clk);
        req = '0;
        ce = 1'b1;
        check(cfg, 16'hf7ff);
        @(negedge clk);
        check(cfg, 16'hf7ff);
        // Each kind alone on its bit, then with every other bit set
        for (int k = 0; k < 20; k++) begin
            send(k, 0, 1'b0, 16'h0100 | (16'h1 << req_bit(k)),
                 1'b1);
            send(k, 0, 1'b0, 16'h01ff & ~(16'h1 << req_bit(k)),
                 1'b0);
        end
        // Every outcome against every response bit, reserved one included
        for (int r = 0; r < 7; r++) begin
            for (int m = 0; m < 2; m++) begin
                for (int b = 8; b < 16; b++) begin
                    send(0, r, m[0], 16'h0001 | (16'h1 << b),
                         rsp_bit(r, m[0]) == b);
                end
            end
        end
        finish_test();
    end

    // Watchdog
    initial begin
        #200us;
        n_fail++;
        finish_test();
    end
endmodule // testbench
